/* ext_bus_area_ctrl.sv */
// External area bus controller: area decode, chip selects, strobes, waits and lane alignment.
// Assumes configuration inputs come from same-clock logic; mode straps and the wait pin are asynchronous.
//
// Summary of operation
// - Each of the eight areas has its own memory interface selection.
// - After reset all areas are basic, three-state; width follows the mode strap.
// - Areas zero and one accept only basic or burst ROM interface.
// - Areas two to five accept basic, DRAM or SDRAM; DRAM selects act as RAS.
// - Contiguous DRAM over areas two to five uses only the area-two select.
// - Contiguous SDRAM drives RAS, CAS, WE, CLK on selects two to five, CKE on OE.
// - Areas six and seven accept basic or multiplexed address/data interface.
// - On-chip RAM in area seven answers only when enabled, else external.
// - An area's select is driven low during an access to its external space.
// - Select pins drive where both direction and pin function bits are set; ROM-less mode starts with area zero output.
// - With on-chip ROM enabled all select pins start as inputs.
// - Eight-bit areas use upper lanes; words take two, longwords four cycles.
// - Sixteen-bit areas move byte or word in one cycle, longword in two.
// - Sixteen-bit byte transfers use upper lanes when even, lower lanes when odd.
// - Read strobe covers both halves; high and low write strobes cover their halves.
// - Unused half floats on writes and is ignored on reads.
// - In eight-bit areas the low-byte write strobe stays high.
// - Sixteen-bit two-state areas add no waits; three-state areas may.
// - Bus width is selectable per area as eight or sixteen bits.
// - Two-state areas take no waits; three-state allow programmed and pin waits.
// - Three-state areas insert zero to seven programmed waits after the second state.
// - With pin waits enabled, a low wait input adds states until it rises.
`timescale 1ns/1ps
`default_nettype none

module ext_bus_area_ctrl
    import ext_bus_pkg::*;
#(
    parameter logic [23:0] ROM_SIZE = 24'h040000,
    parameter logic [23:0] RAM_BASE = 24'hFF0000,
    parameter logic [23:0] RAM_SIZE = 24'h008000
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        modeWide16,
    input  wire logic        romEnabled,
    input  wire logic        waitPin_n,
    input  wire logic        cfgLoad,
    input  wire logic [23:0] cfgInterface,
    input  wire logic [7:0]  cfgWidth8,
    input  wire logic [7:0]  cfgThreeState,
    input  wire logic [23:0] cfgWaits,
    input  wire logic        cfgPinWaitEnable,
    input  wire logic        onchip_ram_enable,
    input  wire logic [7:0]  cfgSelectDir,
    input  wire logic [7:0]  pin_function_ctrl_zero,
    input  wire logic        reqValid,
    output logic             reqReady,
    input  wire logic [23:0] reqAddr,
    input  wire logic        reqWrite,
    input  wire logic [1:0]  reqSize,
    input  wire logic [31:0] reqWdata,
    output logic             respValid,
    output logic             respInternal,
    output logic      [31:0] respRdata,
    output logic      [23:0] extAddr,
    output logic      [7:0]  area_select_n,
    output logic      [7:0]  areaSelectOe,
    output logic             readStrobe_n,
    output logic             high_byte_write_strobe_n,
    output logic             low_byte_write_strobe_n,
    output logic             ckeOut,
    output logic      [15:0] dataOut,
    output logic             dataOeHigh,
    output logic             dataOeLow,
    input  wire logic [15:0] dataIn
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_T1   = 5'b00010,
        ST_T2   = 5'b00100,
        ST_TW   = 5'b01000,
        ST_T3   = 5'b10000
    } bus_state_t;

    bus_state_t  stateR, stateNxt;
    logic [2:0]  syncA_r, syncB_r;
    logic        wide16Sync, romEnSync, waitSync;
    logic [1:0]  strapCntR;
    logic        strapDoneR;
    logic [23:0] ifSelR, waitsR;
    logic [7:0]  width8R, threeR, dirR, pinFuncR;
    logic        pinWaitEnR, ramEnR;
    logic [2:0]  curAreaR, curIfR, waitCntR;
    logic        curWidth8R, curThreeR, curWriteR;
    logic [1:0]  curSizeR, beatIdxR;
    logic [23:0] curAddrR;
    logic [31:0] curWdataR, rdataR;
    logic        sdramClkR;
    logic [2:0]  reqArea, selArea, selIf, beatTotal;
    logic        accept, internalHit, endBeat, lastBeat, busyNxt, strobeNxt;
    logic        useHigh, useLow, sdramContig, dramContig;
    logic [15:0] beatData;
    logic [1:0]  addrOffset;
    logic [7:0]  selectNxt;

    assign wide16Sync = syncB_r[0];
    assign romEnSync  = syncB_r[1];
    assign waitSync   = syncB_r[2];

    // Straps and the wait pin are asynchronous to the bus clock
    always_ff @(posedge clk_sys) begin
        syncA_r <= {waitPin_n, romEnabled, modeWide16};
        syncB_r <= syncA_r;
    end

    // Straps are read only after the synchroniser has settled past reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            strapCntR  <= 2'h0;
            strapDoneR <= 1'b0;
        end else if (!strapDoneR) begin
            strapCntR  <= 2'(strapCntR + 2'h1);
            strapDoneR <= (strapCntR == STRAP_SETTLE);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ifSelR     <= '0;
            threeR     <= RESET_THREE;
            waitsR     <= {AREA_COUNT{RESET_WAITS}};
            width8R    <= WIDTH8_ALL;
            dirR       <= DIR_NONE;
            pinFuncR   <= DIR_NONE;
            pinWaitEnR <= 1'b0;
            ramEnR     <= 1'b0;
        end else if (!strapDoneR) begin
            if (strapCntR == STRAP_SETTLE) begin
                width8R  <= wide16Sync ? WIDTH16_ALL : WIDTH8_ALL;
                dirR     <= romEnSync ? DIR_NONE : DIR_AREA0;
                pinFuncR <= romEnSync ? DIR_NONE : DIR_AREA0;
            end
        end else if (cfgLoad) begin
            for (int a = 0; a < AREA_COUNT; a++) begin
                // Illegal interface codes for an area are refused and leave it basic
                ifSelR[a*IF_W +: IF_W] <= legalIf(3'(a), cfgInterface[a*IF_W +: IF_W]) ?
                                          cfgInterface[a*IF_W +: IF_W] : IF_BASIC;
            end
            width8R    <= cfgWidth8;
            threeR     <= cfgThreeState;
            waitsR     <= cfgWaits;
            pinWaitEnR <= cfgPinWaitEnable;
            ramEnR     <= onchip_ram_enable;
            dirR       <= cfgSelectDir;
            pinFuncR   <= pin_function_ctrl_zero;
        end
    end

    assign sdramContig = (ifSelR[2*IF_W +: IF_W] == IF_SDRAM) && (ifSelR[3*IF_W +: IF_W] == IF_SDRAM) &&
                         (ifSelR[4*IF_W +: IF_W] == IF_SDRAM) && (ifSelR[5*IF_W +: IF_W] == IF_SDRAM);
    assign dramContig  = (ifSelR[2*IF_W +: IF_W] == IF_DRAM) && (ifSelR[3*IF_W +: IF_W] == IF_DRAM) &&
                         (ifSelR[4*IF_W +: IF_W] == IF_DRAM) && (ifSelR[5*IF_W +: IF_W] == IF_DRAM);

    assign reqArea     = reqAddr[ADDR_W-1:AREA_LSB];
    assign internalHit = ((reqArea == AREA_ROM) && romEnSync && (reqAddr < ROM_SIZE)) ||
                         ((reqArea == AREA_RAM) && ramEnR && (reqAddr >= RAM_BASE) &&
                          (reqAddr - RAM_BASE < RAM_SIZE));
    assign reqReady    = (stateR == ST_IDLE) && strapDoneR;
    assign accept      = reqValid && reqReady;
    assign lastBeat    = ({1'b0, beatIdxR} == 3'(beatTotal - BEATS_ONE));
    assign endBeat     = ((stateR == ST_T2) && !curThreeR) || (stateR == ST_T3);

    ext_bus_lane u_lane (
        .width8     (curWidth8R),
        .accSize    (curSizeR),
        .beatIdx    (beatIdxR),
        .addrLsb    (curAddrR[0]),
        .wdata      (curWdataR),
        .beatTotal  (beatTotal),
        .useHigh    (useHigh),
        .useLow     (useLow),
        .beatData   (beatData),
        .addrOffset (addrOffset)
    );

    always_comb begin
        stateNxt = stateR;
        unique case (stateR)
            ST_IDLE: begin
                if (accept && !internalHit) begin
                    stateNxt = ST_T1;
                end
            end
            ST_T1: begin
                stateNxt = ST_T2;
            end
            ST_T2: begin
                if (!curThreeR) begin
                    stateNxt = lastBeat ? ST_IDLE : ST_T1;
                end else if (waitCntR != 3'h0 || (pinWaitEnR && !waitSync)) begin
                    stateNxt = ST_TW;
                end else begin
                    stateNxt = ST_T3;
                end
            end
            ST_TW: begin
                if (waitCntR != 3'h0 || (pinWaitEnR && !waitSync)) begin
                    stateNxt = ST_TW;
                end else begin
                    stateNxt = ST_T3;
                end
            end
            ST_T3: begin
                stateNxt = lastBeat ? ST_IDLE : ST_T1;
            end
            default: begin
                stateNxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stateR <= ST_IDLE;
        end else begin
            stateR <= stateNxt;
        end
    end

    // Area, interface, width, state mode and request are frozen at acceptance; the wait count reloads from waitsR at each T1
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            curAreaR   <= 3'h0;
            curIfR     <= IF_BASIC;
            curWidth8R <= 1'b1;
            curThreeR  <= 1'b1;
            curWriteR  <= 1'b0;
            curSizeR   <= SIZE_BYTE;
            curAddrR   <= '0;
            curWdataR  <= '0;
            beatIdxR   <= 2'h0;
            waitCntR   <= 3'h0;
        end else if (accept) begin
            curAreaR   <= reqArea;
            curIfR     <= ifSelR[reqArea*IF_W +: IF_W];
            curWidth8R <= width8R[reqArea];
            curThreeR  <= threeR[reqArea];
            curWriteR  <= reqWrite;
            curSizeR   <= reqSize;
            curAddrR   <= reqAddr;
            curWdataR  <= reqWdata;
            beatIdxR   <= 2'h0;
        end else begin
            if (stateR == ST_T1) begin
                waitCntR <= curThreeR ? waitsR[curAreaR*WAIT_W +: WAIT_W] : 3'h0;
            end else if (stateNxt == ST_TW && waitCntR != 3'h0) begin
                waitCntR <= 3'(waitCntR - 3'h1);
            end
            if (endBeat && !lastBeat) begin
                beatIdxR <= 2'(beatIdxR + 2'h1);
            end
        end
    end

    // Read data assembles most significant part first
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdataR <= '0;
        end else if (accept) begin
            rdataR <= '0;
        end else if (endBeat && !curWriteR) begin
            if (curWidth8R) begin
                rdataR <= {rdataR[23:0], dataIn[15:8]};
            end else if (curSizeR == SIZE_BYTE) begin
                rdataR <= {24'h000000, useLow ? dataIn[7:0] : dataIn[15:8]};
            end else begin
                rdataR <= {rdataR[15:0], dataIn};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            respValid    <= 1'b0;
            respInternal <= 1'b0;
        end else begin
            respValid    <= (accept && internalHit) || (endBeat && lastBeat);
            respInternal <= accept && internalHit;
        end
    end
    assign respRdata = rdataR;

    assign busyNxt   = (stateNxt != ST_IDLE);
    assign strobeNxt = (stateNxt == ST_T2) || (stateNxt == ST_TW) || (stateNxt == ST_T3);
    assign selArea   = (stateR == ST_IDLE) ? reqArea : curAreaR;
    assign selIf     = (stateR == ST_IDLE) ? ifSelR[reqArea*IF_W +: IF_W] : curIfR;

    always_comb begin
        selectNxt = 8'hFF;
        if (busyNxt) begin
            if (selIf == IF_SDRAM && sdramContig) begin
                selectNxt[2] = 1'b0;
                selectNxt[3] = 1'b0;
                selectNxt[4] = !((stateR == ST_IDLE) ? reqWrite : curWriteR);
                selectNxt[5] = sdramClkR;
            end else if (selIf == IF_DRAM && dramContig) begin
                selectNxt[AREA_DRAM_LO] = 1'b0;
            end else begin
                selectNxt[selArea] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sdramClkR <= 1'b0;
        end else begin
            sdramClkR <= !sdramClkR;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            area_select_n            <= 8'hFF;
            areaSelectOe             <= DIR_NONE;
            readStrobe_n             <= 1'b1;
            high_byte_write_strobe_n <= 1'b1;
            low_byte_write_strobe_n  <= 1'b1;
            ckeOut                   <= 1'b0;
        end else begin
            area_select_n            <= selectNxt;
            areaSelectOe             <= dirR & pinFuncR;
            readStrobe_n             <= !(strobeNxt && !curWriteR);
            high_byte_write_strobe_n <= !(strobeNxt && curWriteR && useHigh);
            low_byte_write_strobe_n  <= !(strobeNxt && curWriteR && useLow && !curWidth8R);
            ckeOut                   <= sdramContig;
        end
    end

    // The unused half stays undriven on writes; reads never drive
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            extAddr    <= '0;
            dataOut    <= '0;
            dataOeHigh <= 1'b0;
            dataOeLow  <= 1'b0;
        end else begin
            extAddr    <= (stateR == ST_IDLE) ? reqAddr : 24'(curAddrR + {22'h0, addrOffset});
            dataOut    <= beatData;
            dataOeHigh <= strobeNxt && curWriteR && useHigh;
            dataOeLow  <= strobeNxt && curWriteR && useLow;
        end
    end

    // Checking helpers
    logic [2:0] t1CountR;
    logic [2:0] twCountR;
    always_ff @(posedge clk_sys) begin
        if (reset || accept) begin
            t1CountR <= 3'h0;
        end else if (stateR == ST_T1) begin
            t1CountR <= 3'(t1CountR + 3'h1);
        end
        if (reset || stateR == ST_T1) begin
            twCountR <= 3'h0;
        end else if (stateR == ST_TW && twCountR != 3'h7) begin
            twCountR <= 3'(twCountR + 3'h1);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_rest_high;
        (&area_select_n) && readStrobe_n && high_byte_write_strobe_n && low_byte_write_strobe_n;
    endsequence

    a_idle_rest_high: assert property ((stateR == ST_IDLE) |-> s_rest_high)
        else $error("select or strobe active while idle");
    a_low_strobe_narrow: assert property ((stateR != ST_IDLE && curWidth8R) |-> low_byte_write_strobe_n)
        else $error("low write strobe asserted in eight-bit area");
    a_two_state_nowait: assert property ((stateR == ST_T1 && !curThreeR) |=> (stateR == ST_T2) ##1 (stateR != ST_TW))
        else $error("wait state in two-state area");
    a_program_waits: assert property ((stateR == ST_T3 && !pinWaitEnR) |->
                                      (twCountR == waitsR[curAreaR*WAIT_W +: WAIT_W]))
        else $error("programmed wait count wrong");
    a_pin_wait_hold: assert property ((stateR inside {ST_T2, ST_TW} && curThreeR && waitCntR == 3'h0 &&
                                       pinWaitEnR && !waitSync) |=> (stateR == ST_TW))
        else $error("wait pin low but no wait inserted");
    a_select_basic: assert property ((stateR != ST_IDLE && curIfR == IF_BASIC) |-> !area_select_n[curAreaR])
        else $error("area select not low during access");
    a_odd_byte_lane: assert property ((stateR == ST_T2 && curWriteR && !curWidth8R && curSizeR == SIZE_BYTE &&
                                       curAddrR[0]) |-> (dataOeLow && !dataOeHigh && high_byte_write_strobe_n &&
                                       !low_byte_write_strobe_n))
        else $error("odd byte write on wrong lane");
    a_beat_split: assert property ((respValid && !respInternal) |->
                                   (t1CountR == $past(expBeats(curWidth8R, curSizeR))))
        else $error("wrong number of bus cycles");
    a_ram_internal: assert property ((accept && internalHit && reqArea == AREA_RAM) |=>
                                     (respValid && respInternal && stateR == ST_IDLE))
        else $error("enabled on-chip RAM access went external");
    a_read_strobe: assert property ((stateR == ST_T2 && !curWriteR) |-> (!readStrobe_n && !dataOeHigh && !dataOeLow))
        else $error("read strobe or drive wrong during read");
endmodule

`default_nettype wire

/* ext_bus_lane.sv */
// Shared constants and the per-beat data lane planner of the external bus controller.
// Assumes the caller holds size, address and write data stable for the whole access.
`timescale 1ns/1ps
`default_nettype none

package ext_bus_pkg;
    localparam int         AREA_COUNT   = 8;
    localparam int         ADDR_W       = 24;
    localparam int         AREA_LSB     = 21;
    localparam int         IF_W         = 3;
    localparam int         WAIT_W       = 3;
    localparam logic [2:0] AREA_DRAM_LO = 3'h2;
    localparam logic [2:0] AREA_DRAM_HI = 3'h5;
    localparam logic [2:0] AREA_ROM     = 3'h0;
    localparam logic [2:0] AREA_RAM     = 3'h7;
    localparam logic [2:0] RESET_WAITS  = 3'h7;
    localparam logic [7:0] RESET_THREE  = 8'hFF;
    localparam logic [7:0] WIDTH8_ALL   = 8'hFF;
    localparam logic [7:0] WIDTH16_ALL  = 8'h00;
    localparam logic [7:0] DIR_AREA0    = 8'h01;
    localparam logic [7:0] DIR_NONE     = 8'h00;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam logic [2:0] BEATS_ONE    = 3'h1;
    localparam logic [2:0] BEATS_TWO    = 3'h2;
    localparam logic [2:0] BEATS_FOUR   = 3'h4;

    typedef enum logic [2:0] {
        IF_BASIC     = 3'h0,
        IF_BURST_ROM = 3'h1,
        IF_DRAM      = 3'h2,
        IF_SDRAM     = 3'h3,
        IF_MUX_IO    = 3'h4
    } mem_if_t;

    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_WORD = 2'h1,
        SIZE_LONG = 2'h2
    } acc_size_t;

    // Which interface an area may take; anything else falls back to basic
    function automatic logic legalIf(input logic [2:0] area, input logic [2:0] code);
        logic ok;
        ok = (code == IF_BASIC);
        if (area <= 3'h1) begin
            ok = ok || (code == IF_BURST_ROM);
        end else if (area <= AREA_DRAM_HI) begin
            ok = ok || (code == IF_DRAM) || (code == IF_SDRAM);
        end else begin
            ok = ok || (code == IF_MUX_IO);
        end
        return ok;
    endfunction

    function automatic logic [2:0] expBeats(input logic width8, input logic [1:0] size);
        logic [2:0] n;
        n = BEATS_ONE;
        if (size == SIZE_LONG) begin
            n = width8 ? BEATS_FOUR : BEATS_TWO;
        end else if (size == SIZE_WORD && width8) begin
            n = BEATS_TWO;
        end
        return n;
    endfunction
endpackage

module ext_bus_lane
    import ext_bus_pkg::*;
(
    input  wire logic        width8,
    input  wire logic [1:0]  accSize,
    input  wire logic [1:0]  beatIdx,
    input  wire logic        addrLsb,
    input  wire logic [31:0] wdata,
    output logic      [2:0]  beatTotal,
    output logic             useHigh,
    output logic             useLow,
    output logic      [15:0] beatData,
    output logic      [1:0]  addrOffset
);
    logic [1:0]  lastIdx;
    logic [1:0]  byteSel;
    logic [31:0] shifted;

    always_comb begin
        beatTotal  = expBeats(width8, accSize);
        lastIdx    = 2'(beatTotal - BEATS_ONE);
        byteSel    = 2'(lastIdx - beatIdx);
        shifted    = wdata >> {byteSel, 3'b000};
        useHigh    = 1'b1;
        useLow     = 1'b0;
        addrOffset = beatIdx;
        beatData   = {shifted[7:0], 8'h00};
        if (width8) begin
            // Narrow area: every beat on the upper lane, most significant byte first
            useHigh = 1'b1;
        end else if (accSize == SIZE_BYTE) begin
            addrOffset = 2'h0;
            useHigh    = !addrLsb;
            useLow     = addrLsb;
            beatData   = addrLsb ? {8'h00, wdata[7:0]} : {wdata[7:0], 8'h00};
        end else begin
            useLow     = 1'b1;
            addrOffset = {beatIdx[0], 1'b0};
            beatData   = (accSize == SIZE_LONG && !beatIdx[0]) ? wdata[31:16] : wdata[15:0];
        end
    end
endmodule

`default_nettype wire

/* ext_mem_model.sv */
// Byte-addressed external memory seen through the upper and lower data lanes.
// Assumes big-endian lanes: a wide device shows the even byte high and the odd byte low,
// while a narrow device shows the byte at the address on the upper lane.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
    input  wire logic        clk_sys,
    input  wire logic [23:0] extAddr,
    input  wire logic        readStrobe_n,
    input  wire logic        highWr_n,
    input  wire logic        lowWr_n,
    input  wire logic        oeHigh,
    input  wire logic        oeLow,
    input  wire logic [15:0] dataOut,
    input  wire logic        stall,
    input  wire logic        narrow,
    output logic      [15:0] dataIn,
    output logic             waitPin_n
);
    logic [7:0]  mem [256];
    logic [15:0] lastRead = 16'h0000;
    // Wide devices ignore address bit zero, so a wrong lane choice reads the neighbour byte
    wire  [7:0]  hiA = narrow ? extAddr[7:0] : {extAddr[7:1], 1'b0};
    wire  [7:0]  loA = extAddr[7:0] | 8'h01;
    initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5A;
    // Released bus shows inverted data so a stale capture cannot pass
    assign dataIn    = readStrobe_n ? ~lastRead : {mem[hiA], mem[loA]};
    assign waitPin_n = !(stall && !readStrobe_n);
    always @(posedge clk_sys) begin
        if (!readStrobe_n) lastRead <= {mem[hiA], mem[loA]};
        if (!highWr_n && oeHigh) mem[hiA] <= dataOut[15:8];
        if (!lowWr_n && oeLow) mem[loA] <= dataOut[7:0];
    end
endmodule
`default_nettype wire

/* test_external_area_bus_interface.sv */
// Self-checking bench: random traffic over random area setups, with corner cases.
// Assumes the memory model wraps on the low eight address bits.
`timescale 1ns/1ps
`default_nettype none
module test_external_area_bus_interface import ext_bus_pkg::*; ;
    logic clk_sys = 0, reset = 1, cfgLoad = 0, pinWait = 0, ramEn = 0, reqValid = 0, reqWrite = 0, stall = 0;
    logic        wide = 1, romOn = 0, dramOn = 0;
    logic [23:0] cfgWaits = 24'hFFFFFF, reqAddr = 0, cfgIf = 0;
    logic [7:0]  w8 = 0, three = 8'hFF, dirBits = 0, pfBits = 0, img [256];
    logic [1:0]  reqSize = 0, s;
    logic [31:0] reqWdata = 0, got, d;
    logic [2:0]  area;
    logic [7:0]  a;
    logic        gotInt, wr;
    wire  [15:0] dOut, dIn;
    wire  [31:0] rData;
    wire  [7:0]  sel, selOe;
    wire         ready, rValid, rInt, rd_n, hw_n, lw_n, oeH, oeL, wt_n, cke;
    wire  [23:0] xAddr;
    int fail_count = 0, check_count = 0, seed = 31835, n, curArea;
    bit busy = 0;
    ext_bus_area_ctrl dut_u (.clk_sys(clk_sys), .reset(reset), .modeWide16(wide), .romEnabled(romOn),
        .waitPin_n(wt_n), .cfgLoad(cfgLoad), .cfgInterface(cfgIf), .cfgWidth8(w8), .cfgThreeState(three),
        .cfgWaits(cfgWaits), .cfgPinWaitEnable(pinWait), .onchip_ram_enable(ramEn), .cfgSelectDir(dirBits),
        .pin_function_ctrl_zero(pfBits), .reqValid(reqValid), .reqReady(ready), .reqAddr(reqAddr),
        .reqWrite(reqWrite), .reqSize(reqSize), .reqWdata(reqWdata), .respValid(rValid), .respInternal(rInt),
        .respRdata(rData), .extAddr(xAddr), .area_select_n(sel), .areaSelectOe(selOe), .readStrobe_n(rd_n),
        .high_byte_write_strobe_n(hw_n), .low_byte_write_strobe_n(lw_n), .ckeOut(cke), .dataOut(dOut),
        .dataOeHigh(oeH), .dataOeLow(oeL), .dataIn(dIn));
    ext_mem_model mem_u (.clk_sys(clk_sys), .extAddr(xAddr), .readStrobe_n(rd_n), .highWr_n(hw_n),
        .lowWr_n(lw_n), .oeHigh(oeH), .oeLow(oeL), .dataOut(dOut), .stall(stall), .narrow(w8[curArea]),
        .dataIn(dIn), .waitPin_n(wt_n));
    initial forever #12.5 clk_sys = ~clk_sys;
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    function logic [31:0] expRead(input logic [7:0] ad, input logic [1:0] sz);
        logic [31:0] r;
        r = 0;
        for (int i = 0; i < (1 << sz); i++) r = {r[23:0], img[ad + i[7:0]]};
        return r;
    endfunction
    // Beats times states per beat, plus the edge that raises the response
    function int expEdges(input int ar, input logic [1:0] sz);
        int nb;
        nb = w8[ar] ? (1 << sz) : (sz == SIZE_LONG ? 2 : 1);
        return nb * (three[ar] ? 3 + int'(cfgWaits[3*ar+:3]) : 2) + 1;
    endfunction
    task xfer(input logic [2:0] ar, input logic [7:0] ad, input logic w, input logic [1:0] sz, input logic [31:0] dt);
        // Area seven traffic lands in the on-chip RAM window
        busy = 1; curArea = ar; reqAddr = {ar, (ar == 3'h7 ? 13'h1F00 : 13'h0), ad};
        reqWrite = w; reqSize = sz; reqWdata = dt; reqValid = 1;
        n = 0;
        while (!ready && n < 300) begin @(negedge clk_sys); n++; end
        @(negedge clk_sys); reqValid = 0; n = 1;
        while (!rValid && n < 300) begin @(negedge clk_sys); n++; end
        got = rData; gotInt = rInt; busy = 0;
    endtask
    always @(negedge clk_sys) if (!reset) begin
        if (!busy) check({sel, rd_n, hw_n, lw_n}, 32'h7FF);
        else if (!rd_n || !hw_n) begin
            check(sel, 8'(~(8'h01 << ((dramOn && curArea inside {[2:5]}) ? 2 : curArea))));
            if (w8[curArea]) check({lw_n, oeL}, 32'h2);
        end
    end
    initial begin
        #(25ns * 30000); fail_count++; end_of_test;
    end
    initial begin
        for (int i = 0; i < 256; i++) img[i] = i[7:0] ^ 8'h5A;
        repeat (6) @(negedge clk_sys); reset = 0;
        repeat (8) @(negedge clk_sys);
        check(selOe, DIR_AREA0);
        xfer(1, 8'h10, 0, SIZE_WORD, 0); check(n, expEdges(1, SIZE_WORD));
        check(got, expRead(8'h10, SIZE_WORD));
        for (int r = 0; r < 6; r++) begin
            w8 = $random(seed); three = $random(seed); cfgWaits = $random(seed) & 24'h6DB6DB;
            dirBits = $random(seed); pfBits = $random(seed); ramEn = r[0];
            cfgLoad = 1; @(negedge clk_sys); cfgLoad = 0; @(negedge clk_sys);
            check(selOe, dirBits & pfBits);
            xfer(7, 8'h00, 0, SIZE_BYTE, 0); check(gotInt, ramEn);
            for (int k = 0; k < 12; k++) begin
                area = 3'($unsigned($random(seed)) % 7); s = 2'($unsigned($random(seed)) % 3);
                a = 8'($random(seed)) & (s == SIZE_BYTE ? 8'hFF : 8'hFE); wr = $random(seed);
                d = $random(seed) & (s == SIZE_BYTE ? 32'hFF : s == SIZE_WORD ? 32'hFFFF : 32'hFFFFFFFF);
                xfer(area, a, wr, s, d); check(n, expEdges(area, s));
                if (wr) for (int i = 0; i < (1 << s); i++) img[a + i[7:0]] = 8'(d >> (8 * ((1 << s) - 1 - i)));
                else check(got, expRead(a, s));
            end
        end
        // Areas two to five as one SDRAM space, then one DRAM space with refused codes on areas zero and six
        cfgIf = 24'h01B6C0; cfgLoad = 1; @(negedge clk_sys); cfgLoad = 0; @(negedge clk_sys);
        check(cke, 1);
        cfgIf = 24'h092482; dramOn = 1; cfgLoad = 1; @(negedge clk_sys); cfgLoad = 0; @(negedge clk_sys);
        check(cke, 0);
        xfer(4, 8'h40, 0, SIZE_BYTE, 0); check(got, expRead(8'h40, SIZE_BYTE));
        xfer(0, 8'h45, 1, SIZE_BYTE, 32'hA5); img[8'h45] = 8'hA5;
        xfer(6, 8'h45, 0, SIZE_BYTE, 0); check(got, expRead(8'h45, SIZE_BYTE));
        // Programmed waits at maximum so the synced wait pin is seen before the last state
        pinWait = 1; three = 8'hFF; w8 = 0; cfgWaits = 24'hFFFFFF;
        cfgLoad = 1; @(negedge clk_sys); cfgLoad = 0; @(negedge clk_sys); stall = 1;
        fork
            xfer(1, 8'h20, 0, SIZE_WORD, 0);
            begin repeat (20) @(negedge clk_sys); stall = 0; end
        join
        check(n > 20 && n < 40, 1);
        check(got, expRead(8'h20, SIZE_WORD));
        // Second reset with the other strap pair: narrow bus, on-chip ROM, every select an input
        wide = 0; romOn = 1; w8 = 8'hFF; three = 8'hFF; cfgWaits = 24'hFFFFFF;
        reset = 1; repeat (2) @(negedge clk_sys); reset = 0; repeat (8) @(negedge clk_sys);
        check(selOe, DIR_NONE);
        xfer(1, 8'h30, 0, SIZE_WORD, 0); check(n, expEdges(1, SIZE_WORD));
        check(got, expRead(8'h30, SIZE_WORD));
        end_of_test;
    end
endmodule
`default_nettype wire
